/* logic/fpl_pkg.sv */
package fpl_pkg;
    // ==================================================================
    // Software register map (APB, one word each)
    localparam logic [7:0]  FPL_REG_CTRL   = 8'h00;
    localparam logic [7:0]  FPL_REG_ARG    = 8'h04;
    localparam logic [7:0]  FPL_REG_PW_LO  = 8'h08;
    localparam logic [7:0]  FPL_REG_PW_HI  = 8'h0c;
    localparam logic [7:0]  FPL_REG_STATUS = 8'h10;
    localparam int          FPL_CTRL_START = 8;
    localparam logic [31:0] FPL_PW_RESET   = 32'hffff_ffff;
    // ==================================================================
    // Lock register layout
    localparam int          FPL_LK_REGION0 = 0;
    localparam int          FPL_LK_PERSIST = 1;
    localparam int          FPL_LK_PASSWD  = 2;
    localparam int          FPL_LK_REGION1 = 6;
    localparam int          FPL_LK_REGION2 = 9;
    localparam int          FPL_LK_REGION3 = 10;
    localparam logic [15:0] FPL_LK_RSVD    = 16'hf1b8;
    // ==================================================================
    // Flash status word layout
    localparam int          FPL_ST_READY   = 7;
    localparam int          FPL_ST_PFAIL   = 4;
    localparam int          FPL_ST_ABORT   = 3;
    // ==================================================================
    // Command cycle addresses and data codes
    localparam logic [15:0] FPL_A_UL1      = 16'h0555;
    localparam logic [15:0] FPL_A_UL2      = 16'h02aa;
    localparam logic [15:0] FPL_D_UL1      = 16'h00aa;
    localparam logic [15:0] FPL_D_UL2      = 16'h0055;
    localparam logic [15:0] FPL_D_LK_ENTER = 16'h0040;
    localparam logic [15:0] FPL_D_PW_ENTER = 16'h0060;
    localparam logic [15:0] FPL_D_GL_ENTER = 16'h0050;
    localparam logic [15:0] FPL_D_PROG     = 16'h00a0;
    localparam logic [15:0] FPL_D_PW_UL1   = 16'h0025;
    localparam logic [15:0] FPL_D_PW_UL2   = 16'h0003;
    localparam logic [15:0] FPL_D_COMMIT   = 16'h0029;
    localparam logic [15:0] FPL_D_STAT     = 16'h0070;
    localparam logic [15:0] FPL_D_SWRST    = 16'h00f0;
    // ==================================================================
    // Timing
    localparam int          FPL_CLK_MHZ      = 100;
    localparam int          FPL_UNLOCK_US    = 1;
    localparam int          FPL_UNLOCK_CYC   = FPL_UNLOCK_US * FPL_CLK_MHZ;
    localparam int          FPL_SETUP_CYC    = 2;
    localparam int          FPL_STROBE_CYC   = 4;
    // ==================================================================
    // Operations
    typedef enum logic [2:0] {
        FPL_OP_LOCK_PROG = 3'b000,
        FPL_OP_PW_PROG   = 3'b001,
        FPL_OP_UNLOCK    = 3'b010,
        FPL_OP_GUARD_LK  = 3'b011,
        FPL_OP_STATUS    = 3'b100,
        FPL_OP_SWRESET   = 3'b101
    } fpl_op_t;
endpackage : fpl_pkg

/* logic/fpl_bus.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// One flash bus cycle, write or read, fixed strobe timing
module fpl_bus
    import fpl_pkg::*;
#(
    parameter int ADDR_W = 26
)(
    // Clocking
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // Request
    input  wire logic              start,
    input  wire logic              wr,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [15:0]       wdata,
    output logic                   done,
    output logic [15:0]            rdata,
    // Flash pins
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [15:0]            dq_o,
    output logic                   dq_oe_n,
    input  wire logic [15:0]       dq_i,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n
);
    typedef enum logic [1:0] {
        FPL_B_IDLE   = 2'b00,
        FPL_B_SETUP  = 2'b01,
        FPL_B_STROBE = 2'b10,
        FPL_B_HOLD   = 2'b11
    } fpl_bst_t;

    typedef struct packed {
        fpl_bst_t          st;
        logic [3:0]        cnt;
        logic              wr;
        logic              done;
        logic [15:0]       rdata;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       dq_o;
        logic              dq_oe_n;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
    } fpl_bus_t;

    fpl_bus_t s_r;
    fpl_bus_t s_nxt;

    // ==================================================================
    // Cycle sequencer
    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            FPL_B_IDLE:
            begin
                if (start)
                begin
                    s_nxt.st      = FPL_B_SETUP;
                    s_nxt.cnt     = 4'(FPL_SETUP_CYC);
                    s_nxt.wr      = wr;
                    s_nxt.addr    = addr;
                    s_nxt.dq_o    = wdata;
                    s_nxt.dq_oe_n = ~wr;   // Drive only on writes
                    s_nxt.ce_n    = 1'b0;
                end
            end
            FPL_B_SETUP:
            begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h1)
                begin
                    s_nxt.st   = FPL_B_STROBE;
                    s_nxt.cnt  = 4'(FPL_STROBE_CYC);
                    s_nxt.we_n = ~s_r.wr;
                    s_nxt.oe_n = s_r.wr;
                end
            end
            FPL_B_STROBE:
            begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h1)
                begin
                    // Sample read data before the strobe rises
                    s_nxt.st    = FPL_B_HOLD;
                    s_nxt.rdata = s_r.wr ? s_r.rdata : dq_i;
                    s_nxt.we_n  = 1'b1;
                    s_nxt.oe_n  = 1'b1;
                end
            end
            FPL_B_HOLD:
            begin
                s_nxt.st      = FPL_B_IDLE;
                s_nxt.ce_n    = 1'b1;
                s_nxt.dq_oe_n = 1'b1;
                s_nxt.done    = 1'b1;
            end
            default: s_nxt.st = FPL_B_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r         <= '0;
            s_r.st      <= FPL_B_IDLE;
            s_r.dq_oe_n <= 1'b1;
            s_r.ce_n    <= 1'b1;
            s_r.oe_n    <= 1'b1;
            s_r.we_n    <= 1'b1;
        end
        else if (clk_en)
        begin
            s_r <= s_nxt;
        end
    end

    assign done       = s_r.done;
    assign rdata      = s_r.rdata;
    assign flash_addr = s_r.addr;
    assign dq_o       = s_r.dq_o;
    assign dq_oe_n    = s_r.dq_oe_n;
    assign ce_n       = s_r.ce_n;
    assign oe_n       = s_r.oe_n;
    assign we_n       = s_r.we_n;
endmodule : fpl_bus
`default_nettype wire

/* logic/fpl_ctrl.sv */
// Summary of operation
// - Host writes ones to reserved bits; locks may be set apart.
// - After wrong password, wait unlock delay, then software reset.
// - Valid password: busy for unlock delay; host polls before next. Here busy ends once status reads ready, with no unlock delay.
// - Program the password before the password mode lock bit.
`timescale 1ns/1ps
`default_nettype none
module fpl_ctrl
    import fpl_pkg::*;
#(
    parameter int ADDR_W     = 26,
    parameter int UNLOCK_CYC = FPL_UNLOCK_CYC
)(
    // Clocking
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Flash pins
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [15:0]            dq_o,
    output logic                   dq_oe_n,
    input  wire logic [15:0]       dq_i,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n,
    input  wire logic              ready_busy_pin
);
    typedef enum logic [2:0] {
        FPL_S_IDLE  = 3'b000,
        FPL_S_STEP  = 3'b001,
        FPL_S_SCMD  = 3'b010,
        FPL_S_SRD   = 3'b011,
        FPL_S_DELAY = 3'b100,
        FPL_S_RST   = 3'b101,
        FPL_S_WAIT  = 3'b110
    } fpl_st_t;

    typedef struct packed {
        fpl_st_t     st;
        fpl_op_t     op;
        logic [3:0]  step;
        logic [31:0] dly;
        logic [15:0] arg;
        logic [1:0]  widx;
        logic [63:0] pw;
        logic [3:0]  pw_done;
        logic        busy;
        logic        done;
        logic        fail;
        logic        refused;
        logic [15:0] fstat;
        logic        bstart;
        logic        bwr;
        logic [15:0] baddr;
        logic [15:0] bdata;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fpl_ctl_t;

    fpl_ctl_t    s_r;
    fpl_ctl_t    s_nxt;
    logic        bus_done;
    logic [15:0] bus_rdata;

    // ==================================================================
    // Command cycle table: {last, address, data} for op and step
    function automatic logic [32:0] step_of(input fpl_op_t op, input logic [3:0] i,
                                            input logic [15:0] arg, input logic [1:0] w,
                                            input logic [63:0] pw);
        logic [15:0] ent;
        logic [15:0] a4;
        logic [15:0] d4;
        ent = (op == FPL_OP_LOCK_PROG) ? FPL_D_LK_ENTER :
              (op == FPL_OP_GUARD_LK)  ? FPL_D_GL_ENTER : FPL_D_PW_ENTER;
        // Password word address keeps sector and word-line bits zero
        a4  = (op == FPL_OP_PW_PROG) ? {14'h0000, w} : 16'h0000;
        d4  = (op == FPL_OP_GUARD_LK) ? 16'h0000 : arg;
        if (op == FPL_OP_SWRESET)
            step_of = {1'b1, 16'h0000, FPL_D_SWRST};
        else if (op == FPL_OP_UNLOCK)
            case (i)
                4'h0:    step_of = {1'b0, FPL_A_UL1, FPL_D_UL1};
                4'h1:    step_of = {1'b0, FPL_A_UL2, FPL_D_UL2};
                4'h2:    step_of = {1'b0, FPL_A_UL1, FPL_D_PW_ENTER};
                4'h3:    step_of = {1'b0, 16'h0000, FPL_D_PW_UL1};
                4'h4:    step_of = {1'b0, 16'h0000, FPL_D_PW_UL2};
                // Four words at addresses 0..3
                4'h5:    step_of = {1'b0, 16'h0000, pw[15:0]};
                4'h6:    step_of = {1'b0, 16'h0001, pw[31:16]};
                4'h7:    step_of = {1'b0, 16'h0002, pw[47:32]};
                4'h8:    step_of = {1'b0, 16'h0003, pw[63:48]};
                default: step_of = {1'b1, 16'h0000, FPL_D_COMMIT};
            endcase
        else
            case (i)
                4'h0:    step_of = {1'b0, FPL_A_UL1, FPL_D_UL1};
                4'h1:    step_of = {1'b0, FPL_A_UL2, FPL_D_UL2};
                4'h2:    step_of = {1'b0, FPL_A_UL1, ent};
                4'h3:    step_of = {1'b0, 16'h0000, FPL_D_PROG};
                default: step_of = {1'b1, a4, d4};
            endcase
    endfunction : step_of

    // ==================================================================
    // Register access and flash sequencing
    always_comb
    begin
        logic [32:0] stp;
        logic        acc;
        logic        lk_ok;
        logic [15:0] lkv;
        stp   = step_of(s_r.op, s_r.step, s_r.arg, s_r.widx, s_r.pw);
        acc   = psel && penable && !s_r.pready;
        // Reserved lock bits written as ones
        lkv   = s_r.arg | FPL_LK_RSVD;
        lk_ok = 1'b1;
        s_nxt        = s_r;
        s_nxt.bstart = 1'b0;
        s_nxt.pready = 1'b0;

        // APB: one wait state, writes commit as pready is seen
        if (acc)
        begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = 1'b0;
            case (paddr)
                FPL_REG_CTRL:   s_nxt.prdata = {29'h0, s_r.op};
                FPL_REG_ARG:    s_nxt.prdata = {14'h0, s_r.widx, s_r.arg};
                FPL_REG_PW_LO:  s_nxt.prdata = s_r.pw[31:0];
                FPL_REG_PW_HI:  s_nxt.prdata = s_r.pw[63:32];
                FPL_REG_STATUS: s_nxt.prdata = {8'h0, s_r.fstat, s_r.pw_done, s_r.refused,
                                                s_r.fail, s_r.done, s_r.busy};
                default:
                begin
                    s_nxt.prdata  = 32'h0000_0000;
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && s_r.pready && pwrite)
        begin
            case (paddr)
                FPL_REG_ARG:
                begin
                    s_nxt.arg  = pwdata[15:0];
                    s_nxt.widx = pwdata[17:16];
                end
                FPL_REG_PW_LO: s_nxt.pw[31:0]  = pwdata;
                FPL_REG_PW_HI: s_nxt.pw[63:32] = pwdata;
                FPL_REG_CTRL:
                begin
                    if (pwdata[FPL_CTRL_START] && !s_r.busy)
                    begin
                        s_nxt.op = fpl_op_t'(pwdata[2:0]);
                        if (s_nxt.op == FPL_OP_LOCK_PROG)
                        begin
                            // Never both mode bits at once
                            if (!lkv[FPL_LK_PERSIST] && !lkv[FPL_LK_PASSWD])
                                lk_ok = 1'b0;
                            // Password mode only once all words programmed
                            if (!lkv[FPL_LK_PASSWD] && s_r.pw_done != 4'hf)
                                lk_ok = 1'b0;
                        end
                        s_nxt.refused = !lk_ok;
                        s_nxt.done    = 1'b0;
                        s_nxt.fail    = 1'b0;
                        if (lk_ok)
                        begin
                            s_nxt.busy = 1'b1;
                            s_nxt.step = 4'h0;
                            s_nxt.st   = (s_nxt.op == FPL_OP_STATUS) ? FPL_S_SCMD : FPL_S_STEP;
                        end
                    end
                end
                default: s_nxt.pslverr = s_r.pslverr;
            endcase
        end

        // Flash side sequencing
        case (s_r.st)
            FPL_S_IDLE: s_nxt.bstart = 1'b0;
            FPL_S_STEP:
            begin
                s_nxt.bstart = 1'b1;
                s_nxt.bwr    = 1'b1;
                s_nxt.baddr  = stp[31:16];
                s_nxt.bdata  = (s_r.op == FPL_OP_LOCK_PROG && stp[32]) ? lkv : stp[15:0];
                s_nxt.st     = FPL_S_WAIT;
            end
            FPL_S_WAIT:
            begin
                if (bus_done)
                begin
                    if (!s_r.bwr)
                    begin
                        s_nxt.fstat = bus_rdata;
                        // Poll until ready
                        if (!bus_rdata[FPL_ST_READY])
                            s_nxt.st = FPL_S_SCMD;
                        else if (bus_rdata[FPL_ST_PFAIL] && s_r.op == FPL_OP_UNLOCK)
                        begin
                            // Wrong password: delay, then reset
                            s_nxt.fail = 1'b1;
                            s_nxt.dly  = 32'(UNLOCK_CYC);
                            s_nxt.st   = FPL_S_DELAY;
                        end
                        else
                        begin
                            // Fail covers locked regions too
                            s_nxt.fail = bus_rdata[FPL_ST_PFAIL];
                            s_nxt.st   = FPL_S_IDLE;
                            s_nxt.busy = 1'b0;
                            s_nxt.done = 1'b1;
                            if (s_r.op == FPL_OP_PW_PROG && !bus_rdata[FPL_ST_PFAIL])
                                s_nxt.pw_done[s_r.widx] = 1'b1;
                        end
                    end
                    else if (stp[32] && s_r.op == FPL_OP_SWRESET)
                    begin
                        s_nxt.st   = FPL_S_IDLE;
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                    else if (stp[32])
                        s_nxt.st = FPL_S_SCMD;
                    else
                    begin
                        s_nxt.step = s_r.step + 4'h1;
                        s_nxt.st   = FPL_S_STEP;
                    end
                end
            end
            FPL_S_SCMD:
            begin
                s_nxt.bstart = 1'b1;
                s_nxt.bwr    = 1'b1;
                s_nxt.baddr  = FPL_A_UL1;
                s_nxt.bdata  = FPL_D_STAT;
                s_nxt.st     = FPL_S_SRD;
            end
            FPL_S_SRD:
            begin
                if (bus_done)
                begin
                    s_nxt.bstart = 1'b1;
                    s_nxt.bwr    = 1'b0;
                    s_nxt.baddr  = 16'h0000;
                    s_nxt.st     = FPL_S_WAIT;
                end
            end
            FPL_S_DELAY:
            begin
                s_nxt.dly = s_r.dly - 32'h1;
                if (s_r.dly <= 32'h1)
                    s_nxt.st = FPL_S_RST;
            end
            FPL_S_RST:
            begin
                // Software reset leaves the overlay space
                s_nxt.op   = FPL_OP_SWRESET;
                s_nxt.step = 4'h0;
                s_nxt.st   = FPL_S_STEP;
            end
            default: s_nxt.st = FPL_S_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r    <= '0;
            s_r.st <= FPL_S_IDLE;
            s_r.pw <= {2{FPL_PW_RESET}};
        end
        else if (clk_en)
        begin
            s_r <= s_nxt;
        end
    end

    // ==================================================================
    // Flash bus cycle engine
    fpl_bus #(.ADDR_W(ADDR_W)) u_bus (
        .clock      (clock),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .start      (s_r.bstart),
        .wr         (s_r.bwr),
        .addr       (ADDR_W'(s_r.baddr)),
        .wdata      (s_r.bdata),
        .done       (bus_done),
        .rdata      (bus_rdata),
        .flash_addr (flash_addr),
        .dq_o       (dq_o),
        .dq_oe_n    (dq_oe_n),
        .dq_i       (dq_i),
        .ce_n       (ce_n),
        .oe_n       (oe_n),
        .we_n       (we_n)
    );

    assign pready  = s_r.pready;
    assign prdata  = s_r.prdata;
    assign pslverr = s_r.pslverr;
endmodule : fpl_ctrl
`default_nettype wire

/* sim/fpl_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Pin and bus timing checks
module fpl_ctrl_asserts
#(
    parameter int ADDR_W = 26
)(
    // Clocking
    input wire logic              clock,
    input wire logic              rst_n,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [7:0]        paddr,
    input wire logic              pready,
    input wire logic              pslverr,
    // Flash pins
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [15:0]       dq_o,
    input wire logic              dq_oe_n,
    input wire logic              ce_n,
    input wire logic              oe_n,
    input wire logic              we_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==================================================================
    // Write strobe steps, read/write exclusion and APB answer checks
    sequence s_strobe; !we_n [*4] ##1 we_n; endsequence
    sequence s_hold; !ce_n ##1 ce_n; endsequence
    property p_strobe; $fell(we_n) |-> s_strobe; endproperty
    property p_hold; $rose(we_n) |-> s_hold; endproperty
    property p_setup; $fell(we_n) |-> !$past(ce_n, 2) && !dq_oe_n; endproperty
    property p_stable; !we_n |-> $stable(flash_addr) && $stable(dq_o); endproperty
    property p_excl; !oe_n |-> we_n && dq_oe_n; endproperty
    property p_answer; psel && penable && !pready |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_slverr; pready |-> pslverr == (paddr > 8'h10); endproperty
    a_strobe: assert property (p_strobe) else $error("strobe width wrong");
    a_hold: assert property (p_hold) else $error("select hold wrong");
    a_setup: assert property (p_setup) else $error("setup wrong");
    a_stable: assert property (p_stable) else $error("address or data moved");
    a_excl: assert property (p_excl) else $error("read overlaps write");
    a_answer: assert property (p_answer) else $error("bus answer late");
    a_pulse: assert property (p_pulse) else $error("ready too long");
    a_slverr: assert property (p_slverr) else $error("error flag wrong");
endmodule : fpl_ctrl_asserts
bind fpl_ctrl fpl_ctrl_asserts #(.ADDR_W(ADDR_W)) u_fpl_ctrl_asserts
    (.clock, .rst_n, .psel, .penable, .paddr, .pready, .pslverr, .flash_addr, .dq_o,
     .dq_oe_n, .ce_n, .oe_n, .we_n);
`default_nettype wire

/* sim/fpl_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Behavioural flash: lock register, password, guard lock
module fpl_flash_model
#(
    parameter int BUSY_CYC = 12
)(
    // Clocking
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Flash pins
    input  wire logic [25:0] flash_addr,
    input  wire logic [15:0] dq_o,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    output logic [15:0]      dq_i,
    output logic             ready_busy_pin,
    // Observation
    output logic [15:0]      lk_r,
    output logic             guard_r,
    output logic [63:0]      pw_r,
    output int               viol
);
    logic       we_q, oe_q, tog, fail, abt;
    logic [1:0] mode, n;
    logic [3:0] hit;
    logic [2:0] stg;
    logic [15:0] d, sw;
    int         busy;
    initial begin lk_r = 16'hfefe; pw_r = '1; viol = 0; end
    // Status word; inverse off the bus so stale data never matches
    assign sw = {8'h00, busy == 0, tog, 1'b0, fail, abt, 3'b000};
    assign dq_i = (!ce_n && !oe_n) ? sw : ~sw;
    assign ready_busy_pin = busy == 0 && !fail;
    // Decoded on the falling clock, clear of the controller's edge
    always @(negedge clock or negedge rst_n)
        if (!rst_n)
        begin
            stg = 0; n = 0; busy = 0; fail = 0; abt = 0; tog = 0; hit = 0; mode = 0;
            guard_r = lk_r[2]; we_q = 1; oe_q = 1;
        end
        else
        begin
            if (busy > 0) busy--;
            if (oe_n && !oe_q) tog = !tog;
            if (we_n && !we_q)
            begin
                d = dq_o;
                if (stg == 3)
                begin
                    hit[flash_addr[1:0]] = d == pw_r[flash_addr[1:0]*16 +: 16];
                    if (flash_addr[15:8] != 0) begin fail = 1; abt = 1; end
                    n++;
                    if (n == 0) stg = 4;
                end
                else if (stg == 4)
                begin
                    stg = 0; busy = BUSY_CYC;
                    if (&hit && !fail) guard_r = 1; else fail = 1;
                end
                else if (stg == 2) begin stg = 3; n = 0; end
                else if (stg == 1)
                begin
                    stg = 0; fail = 0; abt = 0; busy = BUSY_CYC;
                    if (mode == 1)
                    begin
                        if ((~d & 16'hf1b8) != 0) viol++;
                        if (!d[1] && !d[2] || !lk_r[2] && !d[1] || !lk_r[1] && !d[2])
                            fail = 1;
                        else lk_r &= d;
                    end
                    else if (mode == 2 && !lk_r[2]) fail = 1;
                    else if (mode == 2) pw_r[flash_addr[1:0]*16 +: 16] &= d;
                    else if (mode == 3) guard_r = 0;
                end
                else if (d == 16'h00f0) begin mode = 0; fail = 0; abt = 0; end
                else if (d == 16'h00a0) stg = 1;
                else if (d == 16'h0025) begin stg = 2; hit = 0; fail = 0; abt = 0; end
                else if (d == 16'h0040) mode = 1;
                else if (d == 16'h0060) mode = 2;
                else if (d == 16'h0050) mode = 3;
            end
            we_q = we_n; oe_q = oe_n;
        end
endmodule : fpl_flash_model
`default_nettype wire

/* sim/test_flash_protection_lock_logic.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Bench: APB orders, flash model on the pins
module test_flash_protection_lock_logic;
    import fpl_pkg::*;
    localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, s;
    logic        pready, pslverr, dq_oe_n, ce_n, oe_n, we_n, rb, guard, er;
    logic [25:0] flash_addr;
    logic [15:0] dq_o, dq_i, lk;
    logic [63:0] pw;
    int          viol, errors = 0, num_checks = 0;
    fpl_ctrl #(.UNLOCK_CYC(4)) u_fpl_ctrl (.clock, .rst_n, .clk_en(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .flash_addr, .dq_o, .dq_oe_n,
        .dq_i, .ce_n, .oe_n, .we_n, .ready_busy_pin(rb));
    fpl_flash_model u_fpl_flash_model (.clock, .rst_n, .flash_addr, .dq_o, .ce_n, .oe_n,
        .we_n, .dq_i, .ready_busy_pin(rb), .lk_r(lk), .guard_r(guard), .pw_r(pw), .viol);
    initial forever #5 clock = ~clock;
    // ==================================================================
    // Shared tasks
    task automatic chk(input logic [63:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin errors++; $display("BAD %s exp %h seen %h", what, exp, seen); end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask : apb
    task automatic run(input logic [2:0] op, input logic [17:0] arg);
        apb(1, FPL_REG_ARG, {14'h0, arg});
        apb(1, FPL_REG_CTRL, (32'h1 << FPL_CTRL_START) | op);
        repeat (500)
        begin
            apb(0, FPL_REG_STATUS, 0);
            if (rd[0] === 1'b0) break;
        end
        if (rd[0] !== 1'b0) errors++;
        s = rd;
    endtask : run
    task automatic results;
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // ==================================================================
    // Scenarios
    task automatic t_reset;
        chk(lk, 16'hfefe, "lock reg");
        chk(guard, 1, "guard lock");
        apb(0, 8'h20, 0);
        chk(er, 1, "unmapped err");
        run(0, 18'h0fff9);
        chk(s[3], 1, "both modes refused");
        chk(lk, 16'hfefe, "lock reg kept");
        run(4, 0);
        chk(s[15], 1, "status ready");
        run(5, 0);
        chk(s[2:1], 2'b01, "sw reset");
    endtask : t_reset
    task automatic t_program;
        for (int i = 0; i < 4; i++) run(1, {i[1:0], PW[i*16 +: 16]});
        chk(s[7:4], 4'hf, "pw words");
        chk(pw, PW, "stored pw");
        run(0, 18'h0ffbf);
        chk(lk, 16'hfebe, "region lock");
        chk(viol, 0, "reserved ones");
        run(3, 0);
        chk(guard, 0, "guard cleared");
    endtask : t_program
    task automatic t_pwmode;
        run(0, 18'h0fffb);
        chk(lk, 16'hfeba, "pw mode lock");
        run(0, 18'h0fffd);
        chk({s[2], lk}, {1'b1, 16'hfeba}, "persist refused");
        run(1, 18'h0);
        chk(s[2], 1, "pw prog fails");
        chk(pw, PW, "pw unchanged");
    endtask : t_pwmode
    task automatic t_unlock;
        apb(1, FPL_REG_PW_LO, PW[31:0]);
        apb(1, FPL_REG_PW_HI, ~PW[63:32]);
        run(2, 0);
        chk({s[2], guard}, 2'b10, "wrong pw");
        apb(1, FPL_REG_PW_HI, PW[63:32]);
        run(2, 0);
        chk({s[2:1], guard}, 3'b011, "right pw");
        rst_n <= 0;
        repeat (2) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        chk(guard, 0, "guard after reset");
    endtask : t_unlock
    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1;
        t_reset();
        t_program();
        t_pwmode();
        t_unlock();
        results();
    end
    // Hang guard, about 20k cycles
    initial
    begin
        #200000;
        errors++;
        results();
    end
endmodule : test_flash_protection_lock_logic
`default_nettype wire
